// ### rx_config_and_mask_timer.sv
// Purpose: Receiver configuration registers and receive mask timer on AHB-Lite
// Assumes: single word transfers, zero wait states, synchronous inputs
// Notes:   Later-stage gain reaches the receive chain only on the reload or set-default command
//
// Functional notes
// - Receiver output ignored until mask timer expires
// - Mask time equals count times 64 carrier periods
// - Counts zero to four give four steps outside Type A 106k mode
// - Peer detection mode divides mask clock by eight
// - Type A 106k: count means half frame-delay steps
// - Set-default and reset restore all configuration defaults
// - Auto squelch starts after delay, stops at expiry
// - Gain mode bit: first pulses or whole receive
// - Gain algorithm bit selects preset or reset
// - Mixer clock from driver or internal; single internal
// - Split LF input routes inputs to AM, PM
// - First stage codes: full, 2.5 dB steps, boost
// - Clip bit clips first and second stages
// - Later stage codes limited to 0h through Ah
// - Later stage gain loaded only by reload or set-default command
`timescale 1ns/1ps
`default_nettype none
module rx_config_and_mask_timer
  import rx_cfg_pkg::*;
#(
  parameter logic [STEP_W-1:0] MASK_STEP_CYCLES  = STEP_W'(STEP_CYC),
  parameter logic [STEP_W-1:0] TYPEA_HALF_CYCLES = STEP_W'(STEP_CYC),
  parameter logic [SQ_W-1:0]   SQUELCH_CYCLES    = SQ_W'(SQ_DELAY_CYC)
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Direct commands and mode inputs
  input  wire logic        SET_DEFAULT,
  input  wire logic        RESET_RX_GAIN,
  input  wire logic        TX_END,
  input  wire logic        PEER_DETECT_MODE,
  input  wire logic        TYPEA_106_MODE,
  input  wire logic        SINGLE_MODE,
  // Receive data path
  input  wire logic        RX_DATA_IN,
  output logic             RX_DATA_OUT,
  output logic             RX_MASKED,
  output logic             SQUELCH_ON,
  // Receiver settings
  output logic             RECEIVER_LOW_POWER,
  output logic             LOW_FREQ_INPUT_ENABLE,
  output logic             LOW_FREQ_INPUT_SPLIT,
  output logic             AGC_ENABLE,
  output logic             AGC_FULL_PERIOD,
  output logic             AGC_RESET_ALGORITHM,
  output logic             PHASE_MIXER_CLOCK_SELECT,
  output logic             STAGE_CLIP,
  output logic             PEER_GAIN_FORCE,
  // Decoded gain settings
  output logic [2:0]       AM_FIRST_ATTEN,
  output logic             AM_FIRST_BOOST,
  output logic [2:0]       PM_FIRST_ATTEN,
  output logic             PM_FIRST_BOOST,
  output logic [2:0]       AM_WINDOW_STEPS,
  output logic [2:0]       AM_STAGE_STEPS,
  output logic [2:0]       PM_WINDOW_STEPS,
  output logic [2:0]       PM_STAGE_STEPS
);

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
    logic        ready;
    logic [7:0]  cfg_two;
    logic [7:0]  first_gn;
    logic [7:0]  later_gn;
    logic [7:0]  mask_time;
    logic [3:0]  am_later;
    logic [3:0]  pm_later;
    squelch_e    sq;
    logic [SQ_W-1:0] sq_cnt;
    logic        squelch;
    logic        rx_out;
    logic        low_power;
    logic        low_freq_input_enable;
    logic        lf_split;
    logic        agc_en;
    logic        agc_full;
    logic        agc_reset;
    logic        mix_int;
    logic        clip;
    logic        gain_force;
    logic [3:0]  am_first;
    logic [3:0]  pm_first;
    logic [5:0]  am_later_dec;
    logic [5:0]  pm_later_dec;
  } state_s;

  state_s s;
  state_s next_s;

  logic              t_busy;
  logic              t_done;
  logic [UNIT_W-1:0] load_units;
  logic [STEP_W-1:0] step_sel;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] legal_nibble(input logic [3:0] wr, input logic [3:0] old);
    return (wr > LATER_MAX_CODE) ? old : wr;
  endfunction

  // {boost, attenuation steps of 2.5 dB}
  function automatic logic [3:0] first_decode(input logic [2:0] code);
    if (code == FIRST_BOOST_CODE) begin
      return {1'b1, 3'h0};
    end
    return {1'b0, code};
  endfunction

  // {window steps, stage steps}, 3 dB each
  function automatic logic [5:0] later_decode(input logic [3:0] code, input logic force_on);
    logic [3:0] stage;
    stage = (code > WINDOW_MAX_CODE) ? code - WINDOW_MAX_CODE : 4'h0;
    if (force_on) begin
      return {FORCE_WINDOW, FORCE_STAGE};
    end
    if (code > WINDOW_MAX_CODE) begin
      return {WINDOW_MAX_CODE[2:0], stage[2:0]};
    end
    return {code[2:0], 3'h0};
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] idx, input state_s v);
    case (idx)
      IDX_CFG_TWO:   return {24'h000000, v.cfg_two};
      IDX_FIRST_GN:  return {24'h000000, v.first_gn};
      IDX_LATER_GN:  return {24'h000000, v.later_gn};
      IDX_MASK_TIME: return {24'h000000, v.mask_time};
      default:       return 32'h00000000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Mask length selection
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] clamped;
    clamped = (s.mask_time < MIN_MASK_UNITS) ? MIN_MASK_UNITS : s.mask_time;
    if (TYPEA_106_MODE && !PEER_DETECT_MODE) begin
      load_units = UNIT_W'(s.mask_time);
      step_sel   = TYPEA_HALF_CYCLES;
    end else if (PEER_DETECT_MODE) begin
      load_units = UNIT_W'(clamped) << PEER_SHIFT;
      step_sel   = MASK_STEP_CYCLES;
    end else begin
      load_units = UNIT_W'(clamped);
      step_sel   = MASK_STEP_CYCLES;
    end
  end

  mask_timer #(
    .SW (STEP_W),
    .UW (UNIT_W)
  ) u_mask (
    .clk         (CLK_SYS),
    .rst_n       (RST_N),
    .start       (TX_END),
    .load_units  (load_units),
    .step_cycles (step_sel),
    .busy        (t_busy),
    .done        (t_done)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ready = 1'b1;

    // Data phase write; illegal later-stage nibbles keep the old value
    if (s.wr_pend) begin
      case (s.wr_idx)
        IDX_CFG_TWO:   next_s.cfg_two   = HWDATA[7:0];
        IDX_FIRST_GN:  next_s.first_gn  = HWDATA[7:0];
        IDX_LATER_GN:  next_s.later_gn  = {legal_nibble(HWDATA[7:4], s.later_gn[7:4]),
                                           legal_nibble(HWDATA[3:0], s.later_gn[3:0])};
        IDX_MASK_TIME: next_s.mask_time = HWDATA[7:0];
        default: ;
      endcase
    end

    // Reload command copies the stored later-stage codes to the chain
    if (RESET_RX_GAIN) begin
      next_s.am_later = s.later_gn[AM2_LSB +: 4];
      next_s.pm_later = s.later_gn[PM2_LSB +: 4];
    end

    // Command wins over a write landing in the same cycle
    if (SET_DEFAULT) begin
      next_s.cfg_two   = CFG_TWO_DEF;
      next_s.first_gn  = FIRST_GN_DEF;
      next_s.later_gn  = LATER_GN_DEF;
      next_s.mask_time = MASK_TIME_DEF;
      next_s.am_later  = LATER_GN_DEF[AM2_LSB +: 4];
      next_s.pm_later  = LATER_GN_DEF[PM2_LSB +: 4];
    end

    // Address phase; read data reflects a write finishing this cycle
    next_s.wr_pend = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      next_s.wr_idx = (HADDR[1:0] == 2'b00 && HADDR[31:10] == '0) ? HADDR[9:2] : 8'hFF;
      next_s.wr_pend = HWRITE;
      next_s.rdata = HWRITE ? 32'h00000000 : read_mux(next_s.wr_idx, next_s);
    end

    // Squelch sequence
    if (TX_END) begin
      next_s.squelch = 1'b0;
      next_s.sq_cnt  = '0;
      next_s.sq      = next_s.cfg_two[B_SQ_AUTO] ? SQ_WAIT : SQ_IDLE;
    end else begin
      unique case (s.sq)
        SQ_IDLE: next_s.squelch = 1'b0;
        SQ_WAIT: begin
          if (t_done) begin
            next_s.sq = SQ_IDLE;
          end else if (s.sq_cnt == SQUELCH_CYCLES - SQ_W'(1)) begin
            next_s.sq      = SQ_ON;
            next_s.squelch = 1'b1;
          end else begin
            next_s.sq_cnt = s.sq_cnt + SQ_W'(1);
          end
        end
        SQ_ON: begin
          if (t_done) begin
            next_s.sq      = SQ_IDLE;
            next_s.squelch = 1'b0;
          end
        end
      endcase
    end

    // Masked receive output
    next_s.rx_out = RX_DATA_IN && !t_busy && !TX_END;

    // Settings as seen by the analog chain
    next_s.low_power = next_s.cfg_two[B_LOW_POWER];
    next_s.low_freq_input_enable     = next_s.cfg_two[B_LOW_FREQ_INPUT_ENABLE];
    next_s.lf_split  = next_s.cfg_two[B_LOW_FREQ_INPUT_ENABLE] && next_s.cfg_two[B_LF_SPLIT];
    next_s.agc_en    = next_s.cfg_two[B_AGC_EN];
    next_s.agc_full  = next_s.cfg_two[B_AGC_EN] && next_s.cfg_two[B_AGC_MODE];
    next_s.agc_reset = next_s.cfg_two[B_AGC_ALG];
    next_s.mix_int   = next_s.cfg_two[B_MIX_CLK] || SINGLE_MODE;
    next_s.clip      = next_s.first_gn[B_CLIP];
    next_s.gain_force = next_s.first_gn[B_FORCE];
    next_s.am_first  = first_decode(next_s.first_gn[AM1_LSB +: 3]);
    next_s.pm_first  = first_decode(next_s.first_gn[PM1_LSB +: 3]);
    next_s.am_later_dec = later_decode(next_s.am_later, next_s.gain_force);
    next_s.pm_later_dec = later_decode(next_s.pm_later, next_s.gain_force);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s              <= '0;
      s.ready        <= 1'b1;
      s.sq           <= SQ_IDLE;
      s.cfg_two      <= CFG_TWO_DEF;
      s.first_gn     <= FIRST_GN_DEF;
      s.later_gn     <= LATER_GN_DEF;
      s.mask_time    <= MASK_TIME_DEF;
      s.agc_en       <= CFG_TWO_DEF[B_AGC_EN];
      s.agc_full     <= CFG_TWO_DEF[B_AGC_MODE];
      s.am_first     <= {1'b0, FIRST_GN_DEF[AM1_LSB +: 3]};
      s.pm_first     <= {1'b0, FIRST_GN_DEF[PM1_LSB +: 3]};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HRDATA                   = s.rdata;
  assign HREADYOUT                = s.ready;
  assign HRESP                    = 1'b0;
  assign RX_DATA_OUT              = s.rx_out;
  assign RX_MASKED                = t_busy;
  assign SQUELCH_ON               = s.squelch;
  assign RECEIVER_LOW_POWER       = s.low_power;
  assign LOW_FREQ_INPUT_ENABLE    = s.low_freq_input_enable;
  assign LOW_FREQ_INPUT_SPLIT     = s.lf_split;
  assign AGC_ENABLE               = s.agc_en;
  assign AGC_FULL_PERIOD          = s.agc_full;
  assign AGC_RESET_ALGORITHM      = s.agc_reset;
  assign PHASE_MIXER_CLOCK_SELECT = s.mix_int;
  assign STAGE_CLIP               = s.clip;
  assign PEER_GAIN_FORCE          = s.gain_force;
  assign AM_FIRST_ATTEN           = s.am_first[2:0];
  assign AM_FIRST_BOOST           = s.am_first[3];
  assign PM_FIRST_ATTEN           = s.pm_first[2:0];
  assign PM_FIRST_BOOST           = s.pm_first[3];
  assign AM_WINDOW_STEPS          = s.am_later_dec[5:3];
  assign AM_STAGE_STEPS           = s.am_later_dec[2:0];
  assign PM_WINDOW_STEPS          = s.pm_later_dec[5:3];
  assign PM_STAGE_STEPS           = s.pm_later_dec[2:0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  masked_data_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    t_busy |=> !RX_DATA_OUT)
    else $error("receive data passed while masked");

  min_mask_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (TX_END && !PEER_DETECT_MODE && !TYPEA_106_MODE) |-> load_units >= UNIT_W'(MIN_MASK_UNITS))
    else $error("mask shorter than four steps");

  peer_divide_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (TX_END && PEER_DETECT_MODE) |-> load_units[PEER_SHIFT-1:0] == '0
                                     && load_units >= (UNIT_W'(MIN_MASK_UNITS) << PEER_SHIFT))
    else $error("peer mode mask not scaled by eight");

  default_cmd_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SET_DEFAULT |=> s.cfg_two == CFG_TWO_DEF && s.first_gn == FIRST_GN_DEF
                    && s.later_gn == LATER_GN_DEF && s.mask_time == MASK_TIME_DEF)
    else $error("defaults not restored");

  squelch_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(SQUELCH_ON) |-> $past(s.sq) == SQ_WAIT && $past(s.sq_cnt) == SQUELCH_CYCLES - SQ_W'(1))
    else $error("squelch started at wrong time");

  squelch_stop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (t_done && !TX_END) |=> !SQUELCH_ON)
    else $error("squelch not stopped at mask expiry");

  mixer_single_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SINGLE_MODE |=> PHASE_MIXER_CLOCK_SELECT)
    else $error("single mode must use internal mixer clock");

  later_range_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    1'b1 |-> s.later_gn[7:4] <= LATER_MAX_CODE && s.later_gn[3:0] <= LATER_MAX_CODE)
    else $error("later stage code out of range");

  gain_reload_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!RESET_RX_GAIN && !SET_DEFAULT) |=> $stable(s.am_later) && $stable(s.pm_later))
    else $error("later stage gain moved without reload");

endmodule
`default_nettype wire

// ### rx_cfg_pkg.sv
// Purpose: Shared constants for the receiver configuration bank and mask timer
// Assumes: CLK_SYS at 20 MHz, registers on AHB-Lite, one word per register
// Notes:   Printed offsets are register indexes; byte address is four times the index
`default_nettype none
package rx_cfg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 50;
  localparam int STEP_NS      = 4720;    // 64 carrier periods
  localparam int STEP_CYC     = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQ_DELAY_NS  = 18880;   // squelch start after end of transmit
  localparam int SQ_DELAY_CYC = (SQ_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_W       = 12;
  localparam int UNIT_W       = 11;
  localparam int SQ_W         = 9;
  localparam int PEER_SHIFT   = 3;       // extra divide by eight

  localparam logic [7:0] MIN_MASK_UNITS = 8'h04;

  // ----------------------------------------------------------------
  // Register indexes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CFG_TWO   = 8'h0B;
  localparam logic [7:0] IDX_FIRST_GN  = 8'h0C;
  localparam logic [7:0] IDX_LATER_GN  = 8'h0D;
  localparam logic [7:0] IDX_MASK_TIME = 8'h0E;

  localparam logic [7:0] CFG_TWO_DEF   = 8'h1A;
  localparam logic [7:0] FIRST_GN_DEF  = 8'hD8;
  localparam logic [7:0] LATER_GN_DEF  = 8'h00;
  localparam logic [7:0] MASK_TIME_DEF = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_LOW_POWER = 7;
  localparam int B_LF_SPLIT  = 6;
  localparam int B_LOW_FREQ_INPUT_ENABLE     = 5;
  localparam int B_AGC_EN    = 4;
  localparam int B_AGC_MODE  = 3;
  localparam int B_AGC_ALG   = 2;
  localparam int B_SQ_AUTO   = 1;
  localparam int B_MIX_CLK   = 0;
  localparam int AM1_LSB     = 5;
  localparam int PM1_LSB     = 2;
  localparam int B_CLIP      = 1;
  localparam int B_FORCE     = 0;
  localparam int AM2_LSB     = 4;
  localparam int PM2_LSB     = 0;

  // ----------------------------------------------------------------
  // Gain code meanings
  // ----------------------------------------------------------------
  localparam logic [2:0] FIRST_BOOST_CODE = 3'h7;
  localparam logic [3:0] LATER_MAX_CODE   = 4'hA;
  localparam logic [3:0] WINDOW_MAX_CODE  = 4'h4;
  localparam logic [2:0] FORCE_STAGE      = 3'h2;  // 6 dB in 3 dB steps
  localparam logic [2:0] FORCE_WINDOW     = 3'h4;

  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_ON} squelch_e;

endpackage
`default_nettype wire

// ### mask_timer.sv
// Purpose: Mask receive interval counter, prescaled steps times a unit count
// Assumes: start is a one-cycle pulse; load values sampled only on start
// Notes:   busy and done come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module mask_timer
  import rx_cfg_pkg::*;
#(
  parameter int SW = STEP_W,
  parameter int UW = UNIT_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Control
  input  wire logic          start,
  input  wire logic [UW-1:0] load_units,
  input  wire logic [SW-1:0] step_cycles,
  // Status
  output logic               busy,
  output logic               done
);

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [SW-1:0] pre;
    logic [UW-1:0] units;
    logic [SW-1:0] step;
  } timer_s;

  timer_s s;
  timer_s next_s;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start) begin
      // Values latched here; later writes wait for the next start
      next_s.pre   = '0;
      next_s.units = load_units;
      next_s.step  = step_cycles;
      next_s.busy  = (load_units != '0);
      next_s.done  = (load_units == '0);
    end else if (s.busy) begin
      if (s.pre == s.step - SW'(1)) begin
        next_s.pre   = '0;
        next_s.units = s.units - UW'(1);
        if (s.units == UW'(1)) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
      end else begin
        next_s.pre = s.pre + SW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  done_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> ($past(s.units) == UW'(1) && $past(s.busy)) || $past(start))
    else $error("mask timer ended before its last step");

  hold_latched_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.busy && !start) |=> s.step == $past(s.step))
    else $error("mask step changed during interval");

endmodule
`default_nettype wire

// ### card_reply.sv
// Purpose: Card-side reply source feeding the demodulated receive input
// Assumes: one clock, synchronous active-low reset
// Notes:   LFSR state changes every cycle, but rx_bit can repeat, so a stale or masked bit can pass by luck
`timescale 1ns/1ps
`default_nettype none
module card_reply (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Demodulated reply bit
  output logic      rx_bit
);
  logic [7:0] lfsr;

  always_ff @(posedge clk) begin
    if (!rst_n) lfsr <= 8'hA5;
    else lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end
  assign rx_bit = lfsr[0];
endmodule
`default_nettype wire

// ### rx_config_and_mask_timer_bench.sv
// Purpose: Self-checking bench for the receiver settings bank and mask timer
// Assumes: shortened steps (4 cycles a step, squelch delay 6) via parameters
// Notes:   Expected values come from a reference model of integers and tables
`timescale 1ns/1ps
`default_nettype none
module rx_config_and_mask_timer_bench;
  import rx_cfg_pkg::*;
  logic        clk_sys, rst_n, hsel, hwrite, set_default, reset_rx_gain;
  logic        tx_end, peer, typea, single, hreadyout, hresp, rx_in, rx_out;
  logic        masked, sq, lowp, lfen, lfsp, agce, agcf, agca, mix, clip, frc, amb, pmb;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ama, pma, amw, ams, pmw, pms;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  int          err_total, check_count, n, s, e;
  logic [7:0]  dv [4] = '{CFG_TWO_DEF, FIRST_GN_DEF, LATER_GN_DEF, MASK_TIME_DEF};
  int          mr [7] = '{0, 4, 5, 255, 2, 3, 1};
  int          pr [7] = '{0, 0, 0, 0, 1, 0, 1};
  int          ta [7] = '{0, 0, 0, 0, 0, 1, 1};

  // ----------------------------------------------------------------
  // Design, card side and clock
  // ----------------------------------------------------------------
  rx_config_and_mask_timer #(.MASK_STEP_CYCLES(STEP_W'(4)), .TYPEA_HALF_CYCLES(STEP_W'(4)),
    .SQUELCH_CYCLES(SQ_W'(6))) dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SET_DEFAULT(set_default), .RESET_RX_GAIN(reset_rx_gain), .TX_END(tx_end),
    .PEER_DETECT_MODE(peer), .TYPEA_106_MODE(typea), .SINGLE_MODE(single),
    .RX_DATA_IN(rx_in), .RX_DATA_OUT(rx_out), .RX_MASKED(masked), .SQUELCH_ON(sq),
    .RECEIVER_LOW_POWER(lowp), .LOW_FREQ_INPUT_ENABLE(lfen), .LOW_FREQ_INPUT_SPLIT(lfsp),
    .AGC_ENABLE(agce), .AGC_FULL_PERIOD(agcf), .AGC_RESET_ALGORITHM(agca),
    .PHASE_MIXER_CLOCK_SELECT(mix), .STAGE_CLIP(clip), .PEER_GAIN_FORCE(frc),
    .AM_FIRST_ATTEN(ama), .AM_FIRST_BOOST(amb), .PM_FIRST_ATTEN(pma), .PM_FIRST_BOOST(pmb),
    .AM_WINDOW_STEPS(amw), .AM_STAGE_STEPS(ams), .PM_WINDOW_STEPS(pmw), .PM_STAGE_STEPS(pms));
  card_reply card_u (.clk(clk_sys), .rst_n(rst_n), .rx_bit(rx_in));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Single word transfer; waits on hready in both phases
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  // One-cycle command: 1 = set-default, 0 = reload later-stage gain
  task pulse(input logic dflt);
    if (dflt) set_default <= 1'b1;
    else reset_rx_gain <= 1'b1;
    @(posedge clk_sys);
    {set_default, reset_rx_gain} <= 2'b00;
    @(posedge clk_sys);
    #1;
  endtask

  task settle;
    @(posedge clk_sys);
    #1;
  endtask

  // Length of the mask interval and squelch cycles inside it
  task meas;
    tx_end <= 1'b1;
    @(posedge clk_sys);
    tx_end <= 1'b0;
    n = 0;
    s = 0;
    #1;
    while (masked === 1'b1) begin
      chk(rx_out, 0);
      s += (sq === 1'b1);
      n++;
      settle();
    end
  endtask

  task post;
    settle();
    e = rx_in;
    settle();
    chk(rx_out, e);
    chk(sq, 0);
  endtask

  task finish_test;
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, hsel, hwrite, set_default, reset_rx_gain, tx_end, peer, typea, single} = '0;
    {htrans, haddr, hwdata, err_total, check_count} = '0;
    hsize = 3'h2;
    void'($urandom(32'h48B9));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h0B + 8'(i), 32'h0);
      chk(rd, {24'h0, dv[i]});
    end
    chk({hresp, hreadyout, agce, agcf, ama, pma}, 10'h1F6);
    bus(1'b1, 8'h20, 32'hFF);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 0);
    repeat (8) begin
      v = $urandom;
      single <= v[8];
      bus(1'b1, 8'h0B, {24'h0, v[7:0]});
      settle();
      chk({lowp, lfen, lfsp}, {v[7], v[5], v[6] & v[5]});
      chk({agce, agcf, agca}, {v[4], v[4] & v[3], v[2]});
      chk(mix, v[0] | v[8]);
      bus(1'b0, 8'h0B, 32'h0);
      chk(rd, {24'h0, v[7:0]});
    end
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h0C, {24'h0, c[2:0], c[2:0], c[0], 1'b0});
      settle();
      e = (c > 0 && c < 7) ? c : 0;
      chk({ama, amb, pma, pmb}, {e[2:0], c == 7, e[2:0], c == 7});
      chk(clip, c[0]);
    end
    bus(1'b1, 8'h0D, 32'h5A);
    settle();
    chk({amw, ams, pmw, pms}, 0);
    pulse(1'b0);
    chk({amw, ams, pmw, pms}, {3'h4, 3'h1, 3'h4, 3'h6});
    bus(1'b1, 8'h0D, 32'hB3);
    bus(1'b0, 8'h0D, 32'h0);
    chk(rd, 32'h53);
    pulse(1'b0);
    chk({amw, ams, pmw, pms}, {3'h4, 3'h1, 3'h3, 3'h0});
    bus(1'b1, 8'h0C, 32'h01);
    settle();
    chk({frc, amw, ams, pmw, pms}, {1'b1, 3'h4, 3'h2, 3'h4, 3'h2});
    bus(1'b1, 8'h0C, 32'h00);
    pulse(1'b0);
    chk({frc, pmw, pms}, {1'b0, 3'h3, 3'h0});
    bus(1'b1, 8'h0B, 32'h1A);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 8'h0E, mr[i]);
      peer <= pr[i][0];
      typea <= ta[i][0];
      meas();
      e = (ta[i] && !pr[i]) ? mr[i] * 4 : ((mr[i] < 4) ? 4 : mr[i]) * 4 * (pr[i] ? 8 : 1);
      chk(n, e);
      chk(s >= n - 8 && s <= n - 5, 1);
      post();
    end
    {peer, typea} <= 2'b00;
    bus(1'b1, 8'h0B, 32'h18);
    bus(1'b1, 8'h0E, 32'h09);
    fork
      meas();
      begin
        repeat (3) @(posedge clk_sys);
        bus(1'b1, 8'h0E, 32'h14);
      end
    join
    chk(n, 36);
    chk(s, 0);
    post();
    meas();
    chk(n, 80);
    pulse(1'b1);
    chk({amw, ams, pmw, pms}, 0);
    chk({agce, agcf, ama, pma}, 8'hF6);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h0B + 8'(i), 32'h0);
      chk(rd, {24'h0, dv[i]});
    end
    finish_test();
  end
endmodule
`default_nettype wire
